// file: rrs_exec.sv
/*
  Execution of rotate-through-carry, subroutine return and sleep.
  Assumes file_data_i already holds the register addressed by instr_i in
  the same cycle, and that all inputs are synchronous to clock_i.
*/
`timescale 1ns/100ps
module rrs_exec
  import rrs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [DATA_W-1:0] file_data_i,
  input wire logic carry_i,
  input wire logic [PC_W-1:0] stack_top_i,
  input wire logic wake_i,
  output rrs_file_wr_t file_wr_o,
  output rrs_acc_wr_t acc_wr_o,
  output logic carry_we_o,
  output logic carry_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  output logic stack_pop_o,
  output rrs_sleep_fx_t sleep_fx_o,
  output logic busy_o,
  output logic halted_o
);

  rrs_instr_t instr;
  rrs_state_t state_reg;
  logic [1:0] flush_cnt_reg;
  logic accept;
  logic is_rrf;
  logic is_rlf;
  logic is_ret;
  logic is_sleep;
  logic [DATA_W-1:0] rr_data;
  logic [DATA_W-1:0] rl_data;
  logic rr_carry;
  logic rl_carry;
  logic [DATA_W-1:0] rot_data;
  logic rot_carry;
  rrs_file_wr_t file_wr_reg;
  rrs_acc_wr_t acc_wr_reg;
  logic carry_we_reg;
  logic carry_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_reg;
  logic stack_pop_reg;
  rrs_sleep_fx_t sleep_fx_reg;
  logic busy_reg;
  logic halted_reg;

  assign instr = rrs_instr_t'(instr_i);
  // Words offered while flushing or halted are dropped, not queued
  assign accept = ce_i && instr_valid_i && (state_reg == ST_RUN);
  assign is_rrf = (instr.op == OP_ROT_RIGHT);
  assign is_rlf = (instr.op == OP_ROT_LEFT);
  assign is_ret = (instr_i == INSTR_RETURN);
  assign is_sleep = (instr_i == INSTR_SLEEP);

  rrs_rotate #(.LEFT(1'b0)) u_rot_right (
    .data_i(file_data_i),
    .carry_i(carry_i),
    .data_o(rr_data),
    .carry_o(rr_carry)
  );

  rrs_rotate #(.LEFT(1'b1)) u_rot_left (
    .data_i(file_data_i),
    .carry_i(carry_i),
    .data_o(rl_data),
    .carry_o(rl_carry)
  );

  assign rot_data = is_rlf ? rl_data : rr_data;
  assign rot_carry = is_rlf ? rl_carry : rr_carry;

  // Sequencing
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_RUN;
      flush_cnt_reg <= 2'h0;
    end else if (ce_i) begin
      case (state_reg)
        ST_RUN: begin
          if (accept && is_ret) begin
            state_reg <= ST_FLUSH;
            flush_cnt_reg <= FLUSH_CYCLES;
          end else if (accept && is_sleep) begin
            state_reg <= ST_HALT;
          end
        end
        ST_FLUSH: begin
          if (flush_cnt_reg <= 2'h1) begin
            state_reg <= ST_RUN;
            flush_cnt_reg <= 2'h0;
          end else begin
            flush_cnt_reg <= flush_cnt_reg - 2'h1;
          end
        end
        ST_HALT: begin
          if (wake_i) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // Rotate results and carry
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      file_wr_reg <= '{we: 1'b0, addr: RST_FADDR, data: RST_DATA};
      acc_wr_reg <= '{we: 1'b0, data: RST_DATA};
      carry_we_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else if (ce_i) begin
      file_wr_reg.we <= 1'b0;
      acc_wr_reg.we <= 1'b0;
      carry_we_reg <= 1'b0;
      if (accept && (is_rrf || is_rlf)) begin
        carry_we_reg <= 1'b1;
        carry_reg <= rot_carry;
        if (instr.dest == DEST_FILE) begin
          file_wr_reg <= '{we: 1'b1, addr: instr.faddr, data: rot_data};
        end else begin
          acc_wr_reg <= '{we: 1'b1, data: rot_data};
        end
      end
    end
  end

  // Return
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pc_load_reg <= 1'b0;
      pc_reg <= RST_PC;
      stack_pop_reg <= 1'b0;
    end else if (ce_i) begin
      pc_load_reg <= 1'b0;
      stack_pop_reg <= 1'b0;
      if (accept && is_ret) begin
        pc_load_reg <= 1'b1;
        pc_reg <= stack_top_i;
        stack_pop_reg <= 1'b1;
      end
    end
  end

  // Sleep effects and status outputs
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sleep_fx_reg <= '{wdt_clear: 1'b0, pd_clear: 1'b0, to_set: 1'b0};
      busy_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else if (ce_i) begin
      sleep_fx_reg <= '{wdt_clear: 1'b0, pd_clear: 1'b0, to_set: 1'b0};
      if (accept && is_sleep) begin
        sleep_fx_reg <= '{wdt_clear: 1'b1, pd_clear: 1'b1, to_set: 1'b1};
      end
      busy_reg <= (accept && is_ret) || ((state_reg == ST_FLUSH) && (flush_cnt_reg > 2'h1));
      halted_reg <= (accept && is_sleep) || ((state_reg == ST_HALT) && !wake_i);
    end
  end

  assign file_wr_o = file_wr_reg;
  assign acc_wr_o = acc_wr_reg;
  assign carry_we_o = carry_we_reg;
  assign carry_o = carry_reg;
  assign pc_load_o = pc_load_reg;
  assign pc_o = pc_reg;
  assign stack_pop_o = stack_pop_reg;
  assign sleep_fx_o = sleep_fx_reg;
  assign busy_o = busy_reg;
  assign halted_o = halted_reg;

  property p_rrf_value;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && is_rrf |=> carry_we_o && carry_o == $past(file_data_i[0])
      && (file_wr_o.we ? file_wr_o.data : acc_wr_o.data) == {$past(carry_i), $past(file_data_i[7:1])};
  endproperty
  a_rrf_value: assert property (p_rrf_value) else $error("right rotate result wrong");

  property p_dest_acc;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && (is_rrf || is_rlf) && instr.dest == DEST_ACC |=> acc_wr_o.we && !file_wr_o.we;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination not honoured");

  property p_dest_file;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && (is_rrf || is_rlf) && instr.dest == DEST_FILE
      |=> file_wr_o.we && !acc_wr_o.we && file_wr_o.addr == $past(instr_i[6:0]);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination not honoured");

  property p_ret_pc;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && is_ret |=> pc_load_o && stack_pop_o && pc_o == $past(stack_top_i);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return did not load stack top");

  property p_ret_flush;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && is_ret ##1 ce_i |=> !pc_load_o && !file_wr_o.we && !acc_wr_o.we && !carry_we_o;
  endproperty
  a_ret_flush: assert property (p_ret_flush) else $error("prefetched word not discarded");

  property p_rlf_value;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && is_rlf |=> carry_o == $past(file_data_i[7])
      && (file_wr_o.we ? file_wr_o.data : acc_wr_o.data) == {$past(file_data_i[6:0]), $past(carry_i)};
  endproperty
  a_rlf_value: assert property (p_rlf_value) else $error("left rotate result wrong");

  property p_sleep_wdt;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && is_sleep |=> sleep_fx_o.wdt_clear && !pc_load_o;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep did not clear watchdog");

  property p_sleep_flags;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept && is_sleep |=> sleep_fx_o.pd_clear && sleep_fx_o.to_set && halted_o;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep status flags wrong");

  property p_halt_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
    halted_o && ce_i && !wake_i |=> halted_o && !file_wr_o.we && !acc_wr_o.we && !pc_load_o;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("left halt without wake");

endmodule // rrs_exec

// file: rrs_pkg.sv
/*
  Constants, types and field layouts for the rotate / return / sleep
  execution block. Assumes a 14-bit instruction word and an 8-bit data path.
*/
// Functional notes
// - A right rotate through carry (opcode 1100) moves the old carry into bit 7 and the old bit 0 into carry.
// - A rotate with destination bit 0 writes the result to the accumulator and leaves the file register as it was.
// - A rotate with destination bit 1 writes the result back into the file register that was read.
// - Return (00 0000 0000 1000) pops the stack and loads the popped stack top into the program counter.
// - Return takes two instruction cycles because the prefetched word is dropped; rotates take one.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears the power-down flag and sets the timeout flag.
// - After sleep the core halts with the oscillator stopped until a wake-up condition arrives.
package rrs_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int OP_W = 6;

  localparam logic [OP_W-1:0] OP_ROT_RIGHT = 6'h0c;
  localparam logic [OP_W-1:0] OP_ROT_LEFT = 6'h0d;
  localparam logic [INSTR_W-1:0] INSTR_RETURN = 14'h0008;
  localparam logic [INSTR_W-1:0] INSTR_SLEEP = 14'h0063;

  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
  localparam logic [FADDR_W-1:0] RST_FADDR = 7'h00;
  localparam logic [PC_W-1:0] RST_PC = 13'h0000;

  // Cycles taken by return, counted in instruction cycles
  localparam int RET_CYCLES = 2;
  localparam logic [1:0] FLUSH_CYCLES = 2'(RET_CYCLES - 1);

  typedef struct packed {
    logic [OP_W-1:0] op;
    logic dest;
    logic [FADDR_W-1:0] faddr;
  } rrs_instr_t;

  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rrs_file_wr_t;

  typedef struct packed {
    logic we;
    logic [DATA_W-1:0] data;
  } rrs_acc_wr_t;

  typedef struct packed {
    logic wdt_clear;
    logic pd_clear;
    logic to_set;
  } rrs_sleep_fx_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FLUSH,
    ST_HALT
  } rrs_state_t;

endpackage

// file: rrs_rotate.sv
/*
  One-bit rotate through carry, direction chosen by parameter.
  Assumes purely combinational use by the execution block.
*/
`timescale 1ns/100ps
module rrs_rotate
  import rrs_pkg::*;
#(
  parameter bit LEFT = 1'b0
) (
  input wire logic [DATA_W-1:0] data_i,
  input wire logic carry_i,
  output logic [DATA_W-1:0] data_o,
  output logic carry_o
);

  generate
    if (LEFT) begin : g_left
      assign data_o = {data_i[DATA_W-2:0], carry_i};
      assign carry_o = data_i[DATA_W-1];
    end else begin : g_right
      assign data_o = {carry_i, data_i[DATA_W-1:1]};
      assign carry_o = data_i[0];
    end
  endgenerate

endmodule // rrs_rotate

// file: tb.sv
/*
  Self-checking bench for the rotate / return / sleep execution block.
  Assumes the design files of the block are compiled first; one clock only.
*/
`timescale 1ns/100ps
module tb;
  import rrs_pkg::*;

  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic [DATA_W-1:0] file_data_i = '0;
  logic carry_i = 1'b0;
  logic [PC_W-1:0] stack_top_i = '0;
  logic wake_i = 1'b0;
  rrs_file_wr_t file_wr_o;
  rrs_acc_wr_t acc_wr_o;
  logic carry_we_o, carry_o, pc_load_o, stack_pop_o, busy_o, halted_o;
  logic [PC_W-1:0] pc_o;
  rrs_sleep_fx_t sleep_fx_o;
  int failures = 0;
  int checks_done = 0;

  rrs_exec rrs_exec_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .file_data_i(file_data_i), .carry_i(carry_i), .stack_top_i(stack_top_i),
    .wake_i(wake_i), .file_wr_o(file_wr_o), .acc_wr_o(acc_wr_o), .carry_we_o(carry_we_o),
    .carry_o(carry_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .stack_pop_o(stack_pop_o),
    .sleep_fx_o(sleep_fx_o), .busy_o(busy_o), .halted_o(halted_o)
  );

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Leaves valid high so words can follow back to back
  task automatic issue(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] d, input logic c);
    instr_i = w;
    file_data_i = d;
    carry_i = c;
    instr_valid_i = 1'b1;
    @(negedge clock_i);
  endtask

  task automatic idle();
    instr_valid_i = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // All four rotate forms issued back to back
  task automatic t_rotates();
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] res;
    logic c, cout;
    for (int k = 0; k < 8; k++) begin
      d = k[0] ? 8'h35 : 8'he6;
      c = k[0];
      if (k[2]) begin
        res = {d[6:0], c};
        cout = d[7];
      end else begin
        res = {c, d[7:1]};
        cout = d[0];
      end
      issue({k[2] ? OP_ROT_LEFT : OP_ROT_RIGHT, k[1], 7'(8'h11 + k)}, d, c);
      chk("file we", {15'h0, k[1]}, {15'h0, file_wr_o.we});
      chk("acc we", {15'h0, !k[1]}, {15'h0, acc_wr_o.we});
      chk("result", {8'h00, res}, {8'h00, k[1] ? file_wr_o.data : acc_wr_o.data});
      if (k[1]) chk("file addr", 16'(8'h11 + k), {9'h0, file_wr_o.addr});
      chk("carry", {14'h0, 1'b1, cout}, {14'h0, carry_we_o, carry_o});
    end
    idle();
    chk("strobes low", 16'h0000, {13'h0, file_wr_o.we, acc_wr_o.we, carry_we_o});
    $display("test rotates done");
  endtask

  task automatic t_return();
    stack_top_i = 13'h1abc;
    issue(INSTR_RETURN, 8'h00, 1'b0);
    stack_top_i = 13'h0555;
    chk("pc load pop", 16'h0003, {14'h0, pc_load_o, stack_pop_o});
    chk("pc", 16'h1abc, {3'h0, pc_o});
    chk("busy", 16'h0001, {15'h0, busy_o});
    issue({OP_ROT_RIGHT, DEST_FILE, 7'h22}, 8'h81, 1'b0);
    chk("dropped word", 16'h0000, {13'h0, file_wr_o.we, carry_we_o, pc_load_o});
    chk("busy end", 16'h0000, {15'h0, busy_o});
    issue({OP_ROT_RIGHT, DEST_FILE, 7'h22}, 8'h81, 1'b0);
    chk("after return", 16'h0140, {7'h0, file_wr_o.we, file_wr_o.data});
    idle();
    $display("test return done");
  endtask

  task automatic t_sleep();
    int n;
    issue(INSTR_SLEEP, 8'h00, 1'b0);
    instr_valid_i = 1'b0;
    chk("sleep effects", 16'h0007, {13'h0, sleep_fx_o});
    chk("halted", 16'h0001, {15'h0, halted_o});
    chk("no pc load", 16'h0000, {15'h0, pc_load_o});
    @(negedge clock_i);
    issue({OP_ROT_LEFT, DEST_ACC, 7'h05}, 8'h0f, 1'b1);
    repeat (3) begin
      chk("sleep pulse", 16'h0000, {13'h0, sleep_fx_o});
      chk("still halted", 16'h0002, {14'h0, halted_o, acc_wr_o.we});
      @(negedge clock_i);
    end
    idle();
    wake_i = 1'b1;
    n = 0;
    while (halted_o !== 1'b0) begin
      @(negedge clock_i);
      n++;
      if (n > 4) begin
        failures++;
        $display("wrong value wake expected 0 seen %b", halted_o);
        end_of_test();
      end
    end
    wake_i = 1'b0;
    issue({OP_ROT_LEFT, DEST_ACC, 7'h05}, 8'h0f, 1'b1);
    chk("after wake", 16'h011f, {7'h0, acc_wr_o.we, acc_wr_o.data});
    idle();
    $display("test sleep done");
  endtask

  // Enable low must hold strobes and drop offered words
  task automatic t_freeze();
    issue({OP_ROT_RIGHT, DEST_FILE, 7'h33}, 8'h02, 1'b1);
    ce_i = 1'b0;
    instr_valid_i = 1'b0;
    @(negedge clock_i);
    chk("frozen write", 16'h0181, {7'h0, file_wr_o.we, file_wr_o.data});
    chk("frozen carry", 16'h0002, {14'h0, carry_we_o, carry_o});
    issue(INSTR_RETURN, 8'h00, 1'b0);
    chk("frozen return", 16'h0002, {14'h0, file_wr_o.we, pc_load_o});
    ce_i = 1'b1;
    idle();
    chk("thawed", 16'h0000, {13'h0, file_wr_o.we, pc_load_o, busy_o});
    $display("test freeze done");
  endtask

  // Reset while halted, then a word at the first edge after release
  task automatic t_reset_mid();
    issue(INSTR_SLEEP, 8'h00, 1'b0);
    rst_b_i = 1'b0;
    idle();
    rst_b_i = 1'b1;
    chk("reset halt", 16'h0000, {13'h0, halted_o, sleep_fx_o.to_set, busy_o});
    issue({OP_ROT_LEFT, DEST_ACC, 7'h01}, 8'hc1, 1'b0);
    chk("after reset", 16'h0182, {7'h0, acc_wr_o.we, acc_wr_o.data});
    chk("carry after reset", 16'h0003, {14'h0, carry_we_o, carry_o});
    idle();
    $display("test reset again done");
  endtask

  initial begin
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    chk("reset state", 16'h0000, {10'h0, file_wr_o.we, acc_wr_o.we, pc_load_o, busy_o, halted_o, carry_we_o});
    $display("test reset done");
    t_rotates();
    t_return();
    t_sleep();
    t_freeze();
    t_reset_mid();
    end_of_test();
  end
endmodule // tb
